// [pkg/prom_pkg.sv]
// Purpose: shared constants for the one-time threshold store and its serial link
// Assumes: sys_clk at 100 MHz
// Notes: a frame is 14 bits sent bit 0 first; bit 13 is the stop bit
package prom_pkg;
   localparam int CLK_NS = 10;
   // internal clock of the sensor core
   localparam int INT_CLK_NS = 500;
   localparam int INT_CLK_CYC = (INT_CLK_NS + CLK_NS - 1) / CLK_NS;
   // forced-low entry: least low time and watch window after power-up
   localparam int FORCE_MIN_NS = 1000000;
   localparam int FORCE_MIN_CYC = (FORCE_MIN_NS + CLK_NS - 1) / CLK_NS;
   localparam int WATCH_NS = 2000000;
   localparam int WATCH_CYC = WATCH_NS / CLK_NS;
   // supply-sync entry: periods needed and longest lag in internal periods
   localparam logic [2:0] SYNC_PERIODS = 3'h5;
   localparam int SYNC_LAG_PER = 40;
   localparam int SYNC_LAG_CYC = (SYNC_LAG_PER * INT_CLK_NS) / CLK_NS;
   // settle time after releasing the forced output
   localparam int SETTLE_PER = 10;
   localparam int SETTLE_CYC = SETTLE_PER * INT_CLK_CYC;
   // bit cell timing
   localparam int BIT_NS = 100000;
   localparam int BIT_CYC = BIT_NS / CLK_NS;
   localparam int BIT_HALF_CYC = BIT_CYC / 2;
   localparam int WORD_GAP_NS = 150000;
   localparam int WORD_GAP_CYC = WORD_GAP_NS / CLK_NS;
   localparam int EOW_NS = 200000;
   localparam int EOW_CYC = (EOW_NS + CLK_NS - 1) / CLK_NS;
   localparam int SESSION_HI_NS = 500000;
   localparam int SESSION_HI_CYC = SESSION_HI_NS / CLK_NS;
   localparam int EXIT_NS = 1000000;
   localparam int EXIT_CYC = (EXIT_NS + CLK_NS - 1) / CLK_NS;
   // frame layout
   localparam int FRAME_BITS = 14;
   localparam logic [3:0] FRAME_CNT_FULL = 4'hE;
   localparam logic [3:0] PFX_FIRST = 4'hA;
   localparam logic [3:0] PFX_SECOND = 4'hB;
   localparam logic TAIL_BIT = 1'h1;
   localparam logic STOP_BIT = 1'h1;
   localparam logic [13:0] WORD_COMMIT = 14'h2FFF;
   localparam int PFX_LSB = 9;
   localparam int K_LSB = 2;
   localparam int INV_POS = 1;
   localparam int TAIL_POS = 0;
   localparam int STOP_POS = 13;
   // static threshold of a virgin part, mid swing
   localparam logic [6:0] THR_VIRGIN = 7'h40;
   localparam logic [6:0] K_VIRGIN = 7'h40;
   localparam logic INV_VIRGIN = 1'h1;
   localparam int CNT_W = 18;

   // builds a programming frame: {stop, prefix, k, inv, tail}
   function automatic logic [13:0] make_frame(input logic [3:0] pfx,
      input logic [6:0] k, input logic inv);
      make_frame = {STOP_BIT, pfx, k, inv, TAIL_BIT};
   endfunction : make_frame
endpackage : prom_pkg

// [pkg/prom_link_if.sv]
// Purpose: supply-modulated link between sensor and programming station
// Assumes: q line has an external pull-up; either side may pull it low
// Notes: output enables are active low
`timescale 1ns/100ps
interface prom_link_if;
   logic supply_pin;
   logic dev_q_out;
   logic dev_q_oe_n;
   logic sta_q_out;
   logic sta_q_oe_n;
   logic q_level;
   // open-drain wired-and with pull-up
   assign q_level = ~((~dev_q_oe_n & ~dev_q_out) | (~sta_q_oe_n & ~sta_q_out));
   modport device (input supply_pin, input q_level, output dev_q_out, output dev_q_oe_n);
   modport station (output supply_pin, input q_level, output sta_q_out,
      output sta_q_oe_n);
endinterface : prom_link_if

// [design/sensor_end.sv]
// What this block does
// - copy command stores running calibrated threshold
// - station waits calibration after supply-sync entry
// - three words: prefix 1010, 1011, constant
// - fraction is 7-bit, LSB first in field
// - polarity bit 0 inverts output sense
// - station ends session with long supply high
// - station picks fraction, applies programming power
// - forced low 1ms enters test, runs SAR
// - station waits 10 internal periods after release
// - LSB first; last 14 bits form frame
// - long high is 1, short high is 0
// - programmed part refuses entry, stays readable; here it never reaches M_TEST, so its readback frame is never sent
// - station follows output within 40 periods
// Purpose: sensor end: test-mode entry, word receiver, fuse store, output
// Assumes: rst is power-up; fab_rst empties the fuses (virgin part)
// Notes: field_level and cal_level are 7-bit fractions of the swing
`timescale 1ns/100ps
module sensor_end #(
   parameter int FORCE_MIN_CYC = prom_pkg::FORCE_MIN_CYC,
   parameter int WATCH_CYC = prom_pkg::WATCH_CYC,
   parameter int BIT_HALF_CYC = prom_pkg::BIT_HALF_CYC,
   parameter int WORD_GAP_CYC = prom_pkg::WORD_GAP_CYC,
   parameter int SESSION_HI_CYC = prom_pkg::SESSION_HI_CYC
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic fab_rst,
   prom_link_if.device link,
   input wire logic [6:0] field_level,
   input wire logic [6:0] cal_level,
   output logic test_mode,
   output logic sar_busy,
   output logic fuse_done,
   output logic [6:0] thr_level,
   output logic [6:0] k_level,
   output logic inv_bit
);
   typedef enum logic [1:0] {M_WATCH = 2'h0, M_RUN = 2'h1, M_TEST = 2'h3} mode_t;
   typedef enum logic [1:0] {S_IDLE = 2'h0, S_GOT1 = 2'h1, S_GOT2 = 2'h3,
      S_ABORT = 2'h2} seq_t;
   localparam logic [17:0] FORCE_C = 18'(FORCE_MIN_CYC);
   localparam logic [17:0] WATCH_C = 18'(WATCH_CYC);
   localparam logic [17:0] HALF_C = 18'(BIT_HALF_CYC);
   localparam logic [17:0] GAP_C = 18'(WORD_GAP_CYC);
   localparam logic [17:0] SESS_C = 18'(SESSION_HI_CYC);
   localparam logic [17:0] LAG_C = 18'(prom_pkg::SYNC_LAG_CYC);
   localparam logic [17:0] INT_C = 18'(prom_pkg::INT_CLK_CYC);

   // trial value of a successive-approximation step
   function automatic logic [6:0] sar_trial(input logic [6:0] dac, input logic [2:0] b);
      sar_trial = dac | (7'h01 << b);
   endfunction : sar_trial

   mode_t mode_ff;
   seq_t seq_ff;
   logic sup_m_ff, sup_s_ff, sup_d_ff, q_m_ff, q_s_ff, q_d_ff;
   logic [17:0] cnt_ff, lo_ff, hi_ff, miss_ff;
   logic [2:0] per_ff, sar_b_ff;
   logic [6:0] dac_ff, fuse_thr_ff, fuse_k_ff, k_hold_ff;
   logic fuse_inv_ff, inv_hold_ff, forced_ff;
   logic [13:0] rx_ff;
   logic [3:0] rx_n_ff, tx_n_ff;
   logic [12:0] tx_ff;
   logic q_oe_n_ff;

   // edges of the synchronised link pins
   wire sup_rise = sup_s_ff & ~sup_d_ff;
   wire sup_fall = ~sup_s_ff & sup_d_ff;
   wire q_fall = ~q_s_ff & q_d_ff;
   // frame decode of the last 14 bits
   wire got_word = (mode_ff == M_TEST) & ~sup_s_ff & (lo_ff == GAP_C)
      & (rx_n_ff == prom_pkg::FRAME_CNT_FULL);
   wire [6:0] rx_k = rx_ff[prom_pkg::K_LSB +: 7];
   wire rx_inv = rx_ff[prom_pkg::INV_POS];
   wire is_first = rx_ff == prom_pkg::make_frame(prom_pkg::PFX_FIRST, rx_k, rx_inv);
   wire is_second = rx_ff == prom_pkg::make_frame(prom_pkg::PFX_SECOND, k_hold_ff,
      inv_hold_ff);
   wire is_commit = rx_ff == prom_pkg::WORD_COMMIT;
   wire blow = got_word & (seq_ff == S_GOT2) & is_commit;
   wire sess_end = (mode_ff == M_TEST) & (hi_ff == SESS_C);
   // normal output: low above threshold, sense flipped when inv is 0
   wire above = field_level > thr_level;
   wire drive_low = inv_bit ? above : ~above;
   wire sync_ok = (miss_ff < LAG_C);
   wire sar_step = sar_busy & (cnt_ff == INT_C);

   // two-flop synchronisers plus an edge flop; logic reads the second and third stages
   always_ff @(posedge sys_clk)
   begin
      sup_m_ff <= link.supply_pin;
      sup_s_ff <= sup_m_ff;
      sup_d_ff <= sup_s_ff;
      q_m_ff <= link.q_level;
      q_s_ff <= q_m_ff;
      q_d_ff <= q_s_ff;
   end

   // mode control: watch window, both entries, session end
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         mode_ff <= M_WATCH;
         cnt_ff <= '0;
         lo_ff <= '0;
         per_ff <= '0;
         miss_ff <= '0;
         forced_ff <= 1'b0;
         sar_busy <= 1'b0;
         sar_b_ff <= '0;
         dac_ff <= '0;
      end
      else
      begin
         unique case (mode_ff)
            M_WATCH:
            begin
               cnt_ff <= cnt_ff + 18'h1;
               lo_ff <= q_s_ff ? '0 : lo_ff + 18'h1;
               if (fuse_done)
                  mode_ff <= M_RUN;
               else if (lo_ff == FORCE_C)
               begin
                  mode_ff <= M_TEST;
                  forced_ff <= 1'b1;
                  sar_busy <= 1'b1;
                  sar_b_ff <= 3'h6;
                  dac_ff <= '0;
                  cnt_ff <= '0;
               end
               else if (cnt_ff == WATCH_C)
                  mode_ff <= M_RUN;
            end
            M_RUN:
            begin
               // supply must mirror the output inverted, within the lag
               miss_ff <= (sup_s_ff == q_s_ff) ? miss_ff + 18'h1 : '0;
               if (!sync_ok)
                  per_ff <= '0;
               else if (q_fall)
                  per_ff <= per_ff + 3'h1;
               if (!fuse_done && per_ff == prom_pkg::SYNC_PERIODS)
               begin
                  mode_ff <= M_TEST;
                  forced_ff <= 1'b0;
                  per_ff <= '0;
               end
            end
            M_TEST:
            begin
               // one approximation step per internal clock period
               cnt_ff <= sar_step ? '0 : cnt_ff + 18'h1;
               if (sar_step)
               begin
                  if (sar_trial(dac_ff, sar_b_ff) <= field_level)
                     dac_ff <= sar_trial(dac_ff, sar_b_ff);
                  sar_b_ff <= sar_b_ff - 3'h1;
                  if (sar_b_ff == 3'h0)
                     sar_busy <= 1'b0;
               end
               lo_ff <= sup_s_ff ? '0 : lo_ff + 18'h1;
               if (sess_end)
                  mode_ff <= M_RUN;
            end
            default:
               mode_ff <= M_RUN;
         endcase
      end
   end

   // bit receiver and readback shifter
   always_ff @(posedge sys_clk)
   begin
      if (rst || mode_ff != M_TEST)
      begin
         hi_ff <= '0;
         rx_ff <= '0;
         rx_n_ff <= '0;
         tx_ff <= '0;
         tx_n_ff <= '0;
      end
      else
      begin
         hi_ff <= sup_rise ? '0 : (sup_s_ff ? hi_ff + 18'h1 : hi_ff);
         if (sup_fall)
         begin
            // newest bit enters at the top, so bit 0 is the oldest
            rx_ff <= {hi_ff > HALF_C, rx_ff[13:1]};
            if (rx_n_ff != prom_pkg::FRAME_CNT_FULL)
               rx_n_ff <= rx_n_ff + 4'h1;
         end
         if (sup_rise && tx_n_ff != 4'h0)
         begin
            tx_ff <= {1'b0, tx_ff[12:1]};
            tx_n_ff <= tx_n_ff - 4'h1;
         end
         if (got_word)
         begin
            rx_n_ff <= '0;
            tx_ff <= {2'h0, seq_ff, fuse_k_ff, fuse_inv_ff, fuse_done};
            tx_n_ff <= 4'hD;
         end
      end
   end

   // programming sequence; any stray word aborts until session end
   always_ff @(posedge sys_clk)
   begin
      if (rst || sess_end)
      begin
         seq_ff <= S_IDLE;
         k_hold_ff <= '0;
         inv_hold_ff <= 1'b0;
      end
      else if (got_word)
      begin
         unique case (seq_ff)
            S_IDLE:
            begin
               seq_ff <= is_first && !fuse_done ? S_GOT1 : S_ABORT;
               k_hold_ff <= rx_k;
               inv_hold_ff <= rx_inv;
            end
            S_GOT1:
               seq_ff <= is_second ? S_GOT2 : S_ABORT;
            S_GOT2:
               seq_ff <= is_commit ? S_IDLE : S_ABORT;
            S_ABORT:
               seq_ff <= S_ABORT;
         endcase
      end
   end

   // fuse array, survives power-up reset
   always_ff @(posedge sys_clk)
   begin
      if (fab_rst)
      begin
         fuse_done <= 1'b0;
         fuse_thr_ff <= prom_pkg::THR_VIRGIN;
         fuse_k_ff <= prom_pkg::K_VIRGIN;
         fuse_inv_ff <= prom_pkg::INV_VIRGIN;
      end
      else if (blow)
      begin
         fuse_done <= 1'b1;
         // copy path takes the running calibration, forced path the dac
         fuse_thr_ff <= forced_ff ? dac_ff : cal_level;
         fuse_k_ff <= k_hold_ff;
         fuse_inv_ff <= inv_hold_ff;
      end
   end

   // static threshold and sense are latched only at power-up
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         thr_level <= fuse_done ? fuse_thr_ff : prom_pkg::THR_VIRGIN;
         k_level <= fuse_done ? fuse_k_ff : prom_pkg::K_VIRGIN;
         inv_bit <= fuse_done ? fuse_inv_ff : prom_pkg::INV_VIRGIN;
      end
   end

   // output pin: released while watching, readback bits in test mode
   always_ff @(posedge sys_clk)
   begin
      if (rst)
         q_oe_n_ff <= 1'b1;
      else if (mode_ff == M_WATCH)
         q_oe_n_ff <= 1'b1;
      else if (mode_ff == M_TEST)
         q_oe_n_ff <= (tx_n_ff == 4'h0) | tx_ff[0]; // empty buffer reads high
      else
         q_oe_n_ff <= ~drive_low;
   end

   always_ff @(posedge sys_clk)
   begin
      test_mode <= ~rst & (mode_ff == M_TEST);
   end

   assign link.dev_q_out = 1'b0;
   assign link.dev_q_oe_n = q_oe_n_ff;
endmodule : sensor_end

// [design/station_end.sv]
// Purpose: programming station: entry, three words, session end
// Assumes: sensor_calibrated comes from sys_clk logic
// Notes: supply_pin high means the upper supply level
`timescale 1ns/100ps
module station_end #(
   parameter int BIT_CYC = prom_pkg::BIT_CYC,
   parameter int FORCE_CYC = prom_pkg::FORCE_MIN_CYC + prom_pkg::FORCE_MIN_CYC / 10,
   parameter int EOW_CYC = prom_pkg::EOW_CYC,
   parameter int EXIT_CYC = prom_pkg::EXIT_CYC
) (
   input wire logic sys_clk,
   input wire logic rst,
   prom_link_if.station link,
   input wire logic start_forced,
   input wire logic start_copy,
   input wire logic [6:0] k_in,
   input wire logic inv_in,
   input wire logic sensor_calibrated,
   output logic busy,
   output logic done,
   output logic [13:0] readback
);
   typedef enum logic [2:0] {T_IDLE = 3'h0, T_FORCE = 3'h1, T_SETTLE = 3'h3,
      T_SYNC = 3'h2, T_WAITCAL = 3'h6, T_SEND = 3'h7, T_GAP = 3'h5,
      T_EXIT = 3'h4} tstate_t;
   localparam logic [17:0] BIT_C = 18'(BIT_CYC);
   localparam logic [17:0] LONG_C = 18'((2 * BIT_CYC) / 3);
   localparam logic [17:0] SHORT_C = 18'(BIT_CYC / 3);
   localparam logic [17:0] FORCE_C = 18'(FORCE_CYC);
   localparam logic [17:0] EOW_C = 18'(EOW_CYC);
   localparam logic [17:0] EXIT_C = 18'(EXIT_CYC);
   localparam logic [17:0] SETTLE_C = 18'(prom_pkg::SETTLE_CYC);
   localparam logic [2:0] SYNC_TX = prom_pkg::SYNC_PERIODS;

   tstate_t st_ff;
   logic q_m_ff, q_s_ff, q_d_ff, sup_ff, oe_n_ff;
   logic [17:0] tmr_ff;
   logic [3:0] bit_ff;
   logic [1:0] word_ff;
   logic [2:0] per_ff;
   logic [6:0] k_ff;
   logic inv_ff;

   // frame of the word in flight
   wire [13:0] frame = (word_ff == 2'h0) ?
      prom_pkg::make_frame(prom_pkg::PFX_FIRST, k_ff, inv_ff) :
      (word_ff == 2'h1) ? prom_pkg::make_frame(prom_pkg::PFX_SECOND, k_ff, inv_ff) :
      prom_pkg::WORD_COMMIT;
   wire cur_bit = frame[bit_ff];
   wire [17:0] hi_len = cur_bit ? LONG_C : SHORT_C;
   wire bit_end = tmr_ff == BIT_C - 18'h1;
   wire q_fall = ~q_s_ff & q_d_ff;

   // q comes from the far end, so it is synchronised first
   always_ff @(posedge sys_clk)
   begin
      q_m_ff <= link.q_level;
      q_s_ff <= q_m_ff;
      q_d_ff <= q_s_ff;
   end

   // readback: sample q as each bit cell goes low
   always_ff @(posedge sys_clk)
   begin
      if (rst)
         readback <= '0;
      else if (st_ff == T_SEND && tmr_ff == hi_len)
         readback <= {q_s_ff, readback[13:1]};
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         st_ff <= T_IDLE;
         sup_ff <= 1'b1;
         oe_n_ff <= 1'b1;
         tmr_ff <= '0;
         bit_ff <= '0;
         word_ff <= '0;
         per_ff <= '0;
         k_ff <= '0;
         inv_ff <= 1'b0;
         busy <= 1'b0;
         done <= 1'b0;
      end
      else
      begin
         done <= 1'b0;
         tmr_ff <= tmr_ff + 18'h1;
         unique case (st_ff)
            T_IDLE:
            begin
               sup_ff <= 1'b1;
               tmr_ff <= '0;
               bit_ff <= '0;
               word_ff <= '0;
               per_ff <= '0;
               k_ff <= k_in;
               inv_ff <= inv_in;
               if (start_forced)
               begin
                  st_ff <= T_FORCE;
                  oe_n_ff <= 1'b0;
                  sup_ff <= 1'b0;
                  busy <= 1'b1;
               end
               else if (start_copy)
               begin
                  st_ff <= T_SYNC;
                  busy <= 1'b1;
               end
            end
            T_FORCE:
               if (tmr_ff == FORCE_C)
               begin
                  oe_n_ff <= 1'b1;
                  tmr_ff <= '0;
                  st_ff <= T_SETTLE;
               end
            T_SETTLE:
               if (tmr_ff == SETTLE_C)
               begin
                  tmr_ff <= '0;
                  st_ff <= T_SEND;
               end
            T_SYNC:
            begin
               // supply high while q is low, low while q is high
               sup_ff <= ~q_s_ff;
               if (q_fall)
                  per_ff <= per_ff + 3'h1;
               if (per_ff == SYNC_TX)
               begin
                  sup_ff <= 1'b0;
                  st_ff <= T_WAITCAL;
               end
            end
            T_WAITCAL:
            begin
               sup_ff <= 1'b0; // idle low so no session end
               tmr_ff <= '0;
               if (sensor_calibrated)
                  st_ff <= T_SEND;
            end
            T_SEND:
            begin
               sup_ff <= tmr_ff < hi_len;
               if (bit_end)
               begin
                  tmr_ff <= '0;
                  bit_ff <= bit_ff + 4'h1;
                  if (bit_ff == prom_pkg::FRAME_CNT_FULL - 4'h1)
                     st_ff <= T_GAP;
               end
            end
            T_GAP:
            begin
               sup_ff <= 1'b0;
               if (tmr_ff == EOW_C)
               begin
                  tmr_ff <= '0;
                  bit_ff <= '0;
                  word_ff <= word_ff + 2'h1;
                  st_ff <= (word_ff == 2'h2) ? T_EXIT : T_SEND;
               end
            end
            T_EXIT:
            begin
               sup_ff <= 1'b1;
               if (tmr_ff == EXIT_C)
               begin
                  st_ff <= T_IDLE;
                  busy <= 1'b0;
                  done <= 1'b1;
               end
            end
         endcase
      end
   end

   assign link.supply_pin = sup_ff;
   assign link.sta_q_out = 1'b0;
   assign link.sta_q_oe_n = oe_n_ff;
endmodule : station_end

// [verif/threshold_prom_programming_assertions.sv]
// Purpose: concurrent checks on the link between station and sensor
// Assumes: one sys_clk domain; rst synchronous, active high
// Notes: counters see raw link levels; the sensor sees them two cycles later
`timescale 1ns/100ps
module threshold_prom_programming_assertions #(
   parameter int FORCE_MIN = 100,
   parameter int SESSION_HI = 500
) (
   input logic sys_clk,
   input logic rst,
   input logic supply_pin,
   input logic q_level,
   input logic dev_q_out,
   input logic dev_q_oe_n,
   input logic sta_q_out,
   input logic sta_q_oe_n,
   input logic test_mode,
   input logic fuse_done
);
   logic [15:0] hi_ff;
   logic [15:0] lo_ff;
   logic [15:0] frc_ff;

   // run lengths of supply high, q low and station forcing
   always_ff @(posedge sys_clk)
   begin
      hi_ff <= (rst | ~supply_pin) ? 16'h0 : hi_ff + 16'h1;
      lo_ff <= (rst | q_level) ? 16'h0 : lo_ff + 16'h1;
      frc_ff <= (rst | sta_q_oe_n) ? 16'h0 : frc_ff + 16'h1;
   end

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   // release of a forced q, and the end of a test session
   sequence s_release;
      !sta_q_oe_n ##1 sta_q_oe_n;
   endsequence
   sequence s_leave;
      test_mode ##1 !test_mode;
   endsequence

   a_dev_open_drain: assert property (dev_q_out == 1'b0)
      else $error("sensor drives q high");
   a_sta_open_drain: assert property (sta_q_out == 1'b0)
      else $error("station drives q high");
   a_reset_idle: assert property (disable iff (1'b0)
      rst ##1 rst |-> supply_pin && dev_q_oe_n && sta_q_oe_n)
      else $error("link not idle in reset");
   a_force_length: assert property (s_release |-> frc_ff > FORCE_MIN)
      else $error("forced low too short");
   a_dev_quiet_force: assert property (!sta_q_oe_n |-> dev_q_oe_n)
      else $error("sensor pulls q while forced");
   a_force_entry: assert property ($rose(test_mode) && !sta_q_oe_n |-> lo_ff >= FORCE_MIN)
      else $error("test entry before q low long enough");
   a_refuse_entry: assert property (fuse_done && !test_mode |=> !test_mode)
      else $error("programmed part entered test");
   a_stay_test: assert property (s_leave |-> hi_ff >= SESSION_HI)
      else $error("test left without long high");
   a_fuse_hold: assert property (fuse_done |=> fuse_done)
      else $error("fuse state lost");
   a_fuse_in_test: assert property ($rose(fuse_done) |-> test_mode)
      else $error("fuse blown outside test");
endmodule : threshold_prom_programming_assertions

// [verif/threshold_prom_programming_test.sv]
// Purpose: self-checking bench for the station and sensor ends of the link
// Assumes: shortened counts; the station forces q 120 cycles, the sensor needs 100
// Notes: a second sensor on its own link is driven by hand to break the word rules
`timescale 1ns/100ps
module threshold_prom_programming_test;
   typedef struct {logic copy; logic [6:0] k; logic inv; logic [6:0] lvl;} row_t;
   // forced rows store the field, copy rows the running level
   row_t rows [4] = '{'{1'b0, 7'h60, 1'b1, 7'h30}, '{1'b1, 7'h52, 1'b0, 7'h48},
      '{1'b0, 7'h00, 1'b0, 7'h6A}, '{1'b1, 7'h7F, 1'b1, 7'h15}};
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic fab_rst = 1'b1;
   logic [6:0] field_level = 7'h40;
   logic [6:0] cal_level = 7'h40;
   logic start_forced = 1'b0;
   logic start_copy = 1'b0;
   logic [6:0] k_in = 7'h00;
   logic inv_in = 1'b1;
   logic sensor_calibrated = 1'b0;
   logic osc = 1'b0;
   logic busy, done, test_mode, fuse_done, inv_bit, fuse_b, inv_b;
   logic [6:0] thr_level, k_level, k_b;
   int num_errors = 0;
   int checked = 0;
   prom_link_if link();
   prom_link_if link_b();
   localparam int FRC = 100, WCH = 400, HLF = 50, GAP = 150, SES = 500;
   localparam int BIT = 100, SFRC = 120, EOW = 200, EXT = 1000;

   // 100 MHz clock
   always #5 sys_clk = ~sys_clk;
   // swinging field so q toggles around the stored level
   initial forever
   begin
      repeat (300) @(posedge sys_clk);
      if (osc)
         field_level <= field_level ^ 7'h40;
   end

   sensor_end #(.FORCE_MIN_CYC(FRC), .WATCH_CYC(WCH), .BIT_HALF_CYC(HLF),
      .WORD_GAP_CYC(GAP), .SESSION_HI_CYC(SES)) i_sensor_end (.sys_clk(sys_clk),
      .rst(rst), .fab_rst(fab_rst), .link(link.device), .field_level(field_level),
      .cal_level(cal_level), .test_mode(test_mode), .sar_busy(), .fuse_done(fuse_done),
      .thr_level(thr_level), .k_level(k_level), .inv_bit(inv_bit));
   sensor_end #(.FORCE_MIN_CYC(FRC), .WATCH_CYC(WCH), .BIT_HALF_CYC(HLF),
      .WORD_GAP_CYC(GAP), .SESSION_HI_CYC(SES)) i_sensor_end_b (.sys_clk(sys_clk),
      .rst(rst), .fab_rst(fab_rst), .link(link_b.device), .field_level(field_level),
      .cal_level(cal_level), .test_mode(), .sar_busy(), .fuse_done(fuse_b),
      .thr_level(), .k_level(k_b), .inv_bit(inv_b));
   station_end #(.BIT_CYC(BIT), .FORCE_CYC(SFRC), .EOW_CYC(EOW), .EXIT_CYC(EXT))
      i_station_end (.sys_clk(sys_clk), .rst(rst), .link(link.station),
      .start_forced(start_forced), .start_copy(start_copy), .k_in(k_in), .inv_in(inv_in),
      .sensor_calibrated(sensor_calibrated), .busy(busy), .done(done), .readback());
   threshold_prom_programming_assertions i_chk (
      .sys_clk(sys_clk), .rst(rst), .supply_pin(link.supply_pin), .q_level(link.q_level),
      .dev_q_out(link.dev_q_out), .dev_q_oe_n(link.dev_q_oe_n), .sta_q_out(link.sta_q_out),
      .sta_q_oe_n(link.sta_q_oe_n), .test_mode(test_mode), .fuse_done(fuse_done));

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
   endtask : tick

   task automatic chk1(input logic got, input logic exp, input string what);
      checked++;
      if (got !== exp)
      begin
         num_errors++;
         $display("mismatch at %0t: %s got %b", $time, what, got);
      end
   endtask : chk1

   task automatic chk7(input logic [6:0] got, input logic [6:0] exp, input string what);
      checked++;
      if (got !== exp)
      begin
         num_errors++;
         $display("mismatch at %0t: %s got %h", $time, what, got);
      end
   endtask : chk7

   // power-up pulse; fab also empties the fuses
   task automatic power(input logic fab);
      @(posedge sys_clk);
      rst <= 1'b1;
      fab_rst <= fab;
      tick(20);
      rst <= 1'b0;
      fab_rst <= 1'b0;
   endtask : power

   task automatic wait_done();
      for (int n = 0; n < 30000 && done !== 1'b1; n++)
         @(posedge sys_clk);
      chk1(done, 1'b1, "station done");
   endtask : wait_done

   // frame {stop, prefix, fraction, sense, tail} with fraction 0101100, sense 0
   function automatic logic [13:0] fr(input logic [3:0] p);
      fr = {1'b1, p, 7'h2C, 1'b0, 1'b1};
   endfunction : fr

   // bit cells on the second link, junk bits first, then a word gap
   task automatic send_word(input logic [13:0] w, input int junk);
      logic v;
      for (int i = 0; i < junk + 14; i++)
      begin
         v = (i < junk) ? i[0] : w[i - junk];
         link_b.supply_pin <= 1'b1;
         tick(v ? 67 : 33);
         link_b.supply_pin <= 1'b0;
         tick(v ? 33 : 67);
      end
      tick(200);
   endtask : send_word

   task automatic test_done();
      $display("checked %0d num_errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : test_done

   // hang guard, well above the expected run of about 60000 cycles
   initial
   begin
      tick(95000);
      num_errors++;
      test_done();
   end

   initial
   begin
      row_t r;
      link_b.supply_pin = 1'b1;
      link_b.sta_q_out = 1'b0;
      link_b.sta_q_oe_n = 1'b1;
      foreach (rows[i])
      begin
         r = rows[i];
         @(posedge sys_clk);
         field_level <= r.copy ? 7'h20 : r.lvl;
         cal_level <= r.lvl;
         k_in <= r.k;
         inv_in <= r.inv;
         sensor_calibrated <= 1'b0;
         osc <= r.copy;
         power(1'b1);
         start_forced <= ~r.copy;
         start_copy <= r.copy;
         @(posedge sys_clk);
         start_forced <= 1'b0;
         start_copy <= 1'b0;
         if (r.copy)
         begin
            for (int n = 0; n < 20000 && test_mode !== 1'b1; n++)
               @(posedge sys_clk);
            chk1(test_mode, 1'b1, "sync entry");
            sensor_calibrated <= 1'b1;
         end
         wait_done();
         chk1(busy, 1'b0, "busy");
         chk7(thr_level, 7'h40, "level before power-up");
         osc <= 1'b0;
         power(1'b0);
         chk1(fuse_done, 1'b1, "fuse");
         chk7(thr_level, r.lvl, "level");
         chk7(k_level, r.k, "fraction");
         chk1(inv_bit, r.inv, "sense");
         field_level <= r.lvl + 7'h10;
         tick(450);
         chk1(link.q_level, ~r.inv, "q above level");
         field_level <= r.lvl - 7'h10;
         tick(30);
         chk1(link.q_level, r.inv, "q below level");
         $display("row %0d finished", i);
      end
      // a programmed part ignores both ways in
      for (int m = 0; m < 2; m++)
      begin
         field_level <= 7'h05;
         osc <= m[0];
         power(1'b0);
         start_forced <= ~m[0];
         start_copy <= m[0];
         @(posedge sys_clk);
         start_forced <= 1'b0;
         start_copy <= 1'b0;
         wait_done();
         osc <= 1'b0;
         power(1'b0);
         chk7(k_level, 7'h7F, "kept fraction");
         chk7(thr_level, 7'h15, "kept level");
         $display("refusal %0d finished", m);
      end
      // second link: words out of order, then three extra leading bits
      for (int f = 0; f < 2; f++)
      begin
         power(1'b1);
         link_b.sta_q_oe_n <= 1'b0;
         link_b.supply_pin <= 1'b0;
         tick(120);
         link_b.sta_q_oe_n <= 1'b1;
         tick(600);
         send_word(fr(f ? prom_pkg::PFX_FIRST : prom_pkg::PFX_SECOND), f * 3);
         send_word(fr(f ? prom_pkg::PFX_SECOND : prom_pkg::PFX_FIRST), 0);
         send_word(prom_pkg::WORD_COMMIT, 0);
         link_b.supply_pin <= 1'b1;
         tick(1000);
         power(1'b0);
         chk1(fuse_b, f[0], "order");
         chk7(k_b, f ? 7'h2C : 7'h40, "fraction b");
         chk1(inv_b, ~f[0], "sense b");
         $display("fault %0d finished", f);
      end
      test_done();
   end
endmodule : threshold_prom_programming_test
